/* File: pkg/adc_cal_seq_pkg.sv */
// constants shared by the calibration sequencer and its bench
package adc_cal_seq_pkg;

  // register word addresses on the plain register port
  localparam logic [7:0] ADDR_MODE       = 8'h00; // mode, channel and gain
  localparam logic [7:0] ADDR_STATUS     = 8'h04; // live status, read only
  localparam logic [7:0] ADDR_DATA       = 8'h08; // latest conversion word
  localparam logic [7:0] ADDR_ZS_COEF    = 8'h0C; // zero-scale coefficient
  localparam logic [7:0] ADDR_FS_COEF    = 8'h10; // full-scale coefficient
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14; // sticky events, read only
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h18; // write one to clear, write only
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1C; // event enables

  // mode register field positions
  localparam int MODE_LSB = 0; // op_mode_bit0 .. op_mode_bit2
  localparam int CHAN_LSB = 3; // chan_sel_bit0 .. chan_sel_bit2
  localparam int GAIN_LSB = 6; // gain code
  localparam int FIELD_W  = 3; // width of each mode register field

  // status register bit positions
  localparam int STAT_READY_N = 0; // mirror of conv_word_ready_n
  localparam int STAT_CAL     = 1; // single-step calibration pending
  localparam int STAT_BG      = 2; // background calibration running

  // operating-mode encodings handled here
  localparam logic [2:0] MODE_NORMAL   = 3'h0; // normal conversion
  localparam logic [2:0] MODE_SYS_OFFS = 3'h4; // system offset calibration
  localparam logic [2:0] MODE_BG_CAL   = 3'h5; // background calibration
  localparam logic [2:0] MODE_SELF_ZS  = 3'h6; // zero-scale self-calibration

  // measurement source codes presented to the front end
  localparam logic [1:0] SRC_AIN   = 2'h0; // selected analog input
  localparam logic [1:0] SRC_SHORT = 2'h1; // internally shorted inputs
  localparam logic [1:0] SRC_REF   = 2'h2; // internal reference over gain

  // interrupt event bit positions
  localparam int EV_WORD   = 0; // new conversion word stored
  localparam int EV_CAL    = 1; // single-step calibration finished
  localparam int EV_BG_UPD = 2; // background offset coefficient updated
  localparam int EV_W      = 3; // number of events

  // background mode: one conversion plus this many offset slots per word,
  // so the word rate drops by a factor of six
  localparam logic [2:0] BG_CAL_SLOTS = 3'h5;

  // reset values
  localparam logic [2:0] RST_GAIN = 3'h0; // gain code after reset
  localparam logic [2:0] RST_CHAN = 3'h0; // channel after reset

endpackage

/* File: rtl/adc_cal_sequencer.sv */
`timescale 1ns/1ps
// Overview of operation
// R1: mode 100 runs system offset calibration
// R2: single-step calibrations finish, then mode returns 000
// R3: ready high at start, low on fresh word
// R4: system offset zero-scale from analog input voltage
// R5: system offset full-scale from reference over gain
// R6: mode 101 starts background offset calibration on shorts
// R7: interleave offset slots, word rate falls sixfold
// R8: background updates offset only, never full-scale
// R9: host should self-calibrate before background mode
// R10: mode 110 runs zero-scale self-calibration on shorts
// R11: ready high at start, low on new word
// R12: host waits for ready low before next change

// register map, 32-bit words
// 0x00 mode, channel and gain
// 0x04 live status, read only
// 0x08 data word, read only
// 0x0C zero-scale value
// 0x10 full-scale value
// 0x14 sticky events
// 0x18 event clear, write only
// 0x1C event enables
// status bits
// bit 0 mirrors ready
// bit 1 calibration pending
// bit 2 background running
// event bits
// bit 0 new word stored
// bit 1 calibration finished
// bit 2 offset refreshed
// bus timing
// reads answer one cycle later,
// zero in every other cycle
// writes act at the strobe edge
// front end link
// start asks for one result
// done answers each start once
// abort drops a running one
// one measurement at a time
// mode sequences
// 100: input step, then reference
// 110: shorted step only
// 101: one word, five offset slots
// others: plain conversions
// user hazards
// mode write loses running result
// cal done flags first word after
// full-scale untouched in background
// ready stays high during calibration
// data word wraps at its width
module adc_cal_sequencer #(
  parameter int DATA_W = 24                  // conversion and coefficient width
) (
  input  wire logic              clk_sys,    // system clock, 100 MHz
  input  wire logic              rst,        // synchronous reset, active high
  input  wire logic [7:0]        addr,       // register word address
  input  wire logic [31:0]       wr_data,    // register write data
  input  wire logic              wr_en,      // one-cycle write strobe
  input  wire logic              rd_en,      // one-cycle read strobe
  output logic      [31:0]       rd_data,    // read data, cycle after rd_en
  input  wire logic              meas_done,  // front end finished a measurement
  input  wire logic [DATA_W-1:0] meas_data,  // result beside meas_done
  output logic                   meas_start, // one-cycle measurement request
  output logic                   meas_abort, // one-cycle cancel of running one
  output logic      [1:0]        meas_src,   // what the front end measures
  output logic      [2:0]        meas_chan,  // channel of the measurement
  output logic      [2:0]        meas_gain,  // gain of the measurement
  output logic                   conv_word_ready_n, // low while a new word waits
  output logic                   irq         // level interrupt
);

  // the front end owns all timing,
  // so two states are enough here
  // sequencer states
  typedef enum logic [0:0] {
    ST_LAUNCH,                               // issue the next measurement
    ST_WAIT                                  // wait for the front end result
  } st_t;

  // phase picks source and target
  // of the measurement in flight
  // what the running measurement is for
  typedef enum logic [2:0] {
    PH_CONV,                                 // ordinary conversion
    PH_SYS_ZS,                               // system offset, zero-scale step
    PH_SYS_FS,                               // system offset, full-scale step
    PH_SELF_ZS,                              // zero-scale self-calibration
    PH_BG_ZS                                 // background offset slot
  } phase_t;

  // everything registered lives here,
  // so reset and update stay together
  // all state of the block
  typedef struct packed {
    st_t                          state;     // sequencer state
    phase_t                       phase;     // purpose of current measurement
    logic                         op_mode_bit2; // operating mode, upper bit
    logic                         op_mode_bit1; // operating mode, middle bit
    logic                         op_mode_bit0; // operating mode, lower bit
    logic                         chan_sel_bit2; // channel select, upper bit
    logic                         chan_sel_bit1; // channel select, middle bit
    logic                         chan_sel_bit0; // channel select, lower bit
    logic [2:0]                   gain;      // gain code
    logic                         cal_pending; // waiting for first word after cal
    logic [2:0]                   bg_cnt;    // offset slots done this word
    logic [DATA_W-1:0]            data_word; // data register
    logic [DATA_W-1:0]            zs_coef;   // zero-scale coefficient
    logic [DATA_W-1:0]            fs_coef;   // full-scale coefficient
    logic                         ready_n;   // data-ready, active low
    logic [adc_cal_seq_pkg::EV_W-1:0] irq_stat; // sticky events
    logic [adc_cal_seq_pkg::EV_W-1:0] irq_en;   // event enables
    logic                         irq;       // registered interrupt
    logic [31:0]                  rd_data;   // registered read data
    logic                         meas_start; // request pulse
    logic                         meas_abort; // cancel pulse
    logic [1:0]                   meas_src;  // source of measurement
  } state_t;

  state_t cur;                               // registered state
  state_t nxt;                               // next state

  logic [adc_cal_seq_pkg::EV_W-1:0] events;  // events raised this cycle
  logic [2:0]                   op_mode;     // mode field as a vector
  logic [2:0]                   new_mode;    // mode field being written
  logic                         hit_data_rd; // read of the data register

  // helpers decoded from the state
  // and from the bus write data, read strobe and address
  // mode field gathered from its three bits
  assign op_mode  = {cur.op_mode_bit2, cur.op_mode_bit1, cur.op_mode_bit0};
  assign new_mode = wr_data[adc_cal_seq_pkg::MODE_LSB +: adc_cal_seq_pkg::FIELD_W];
  assign hit_data_rd = rd_en && (addr == adc_cal_seq_pkg::ADDR_DATA);

  // order inside the pass matters:
  // a mode write comes last and wins
  // over the sequencer's own choice;
  // pulses and read data default to
  // zero and rise for one cycle only
  // next-state logic: sequencer, then register reads, then register writes
  always_comb begin
    nxt            = cur;
    events         = '0;
    nxt.meas_start = 1'b0;
    nxt.meas_abort = 1'b0;
    nxt.rd_data    = '0;

    // launch issues a start, then waits;
    // a result is ignored unless waiting
    // measurement sequencer
    unique case (cur.state)
      ST_LAUNCH: begin
        // pick the source the current phase needs
        unique case (cur.phase)
          PH_CONV:    nxt.meas_src = adc_cal_seq_pkg::SRC_AIN;
          PH_SYS_ZS:  nxt.meas_src = adc_cal_seq_pkg::SRC_AIN;   // R4
          PH_SYS_FS:  nxt.meas_src = adc_cal_seq_pkg::SRC_REF;   // R5
          PH_SELF_ZS: nxt.meas_src = adc_cal_seq_pkg::SRC_SHORT; // R10
          PH_BG_ZS:   nxt.meas_src = adc_cal_seq_pkg::SRC_SHORT; // R6
        endcase
        // one-cycle request, then wait
        nxt.meas_start = 1'b1;
        nxt.state      = ST_WAIT;
      end
      ST_WAIT: begin
        // answer taken on any waiting edge
        if (meas_done) begin
          nxt.state = ST_LAUNCH;
          unique case (cur.phase)
            PH_CONV: begin
              // offset-corrected word goes to the data register
              // the subtraction wraps silently
              nxt.data_word = meas_data - cur.zs_coef;
              nxt.ready_n   = 1'b0;                              // R3 R11
              events[adc_cal_seq_pkg::EV_WORD] = 1'b1;
              if (cur.cal_pending) begin
                // first fresh word after a single-step calibration
                nxt.cal_pending = 1'b0;
                events[adc_cal_seq_pkg::EV_CAL] = 1'b1;
              end
              if (op_mode == adc_cal_seq_pkg::MODE_BG_CAL) begin
                // follow each word with the offset slots
                nxt.phase  = PH_BG_ZS;                           // R7
                nxt.bg_cnt = '0;
              end
            end
            PH_SYS_ZS: begin
              // zero-scale from the voltage on the analog input
              // input should stay still meanwhile
              nxt.zs_coef = meas_data;                           // R4
              nxt.phase   = PH_SYS_FS;                           // R1
            end
            PH_SYS_FS: begin
              // full-scale from reference over gain, then back to normal
              // the mode field clears itself here
              nxt.fs_coef      = meas_data;                      // R5
              nxt.op_mode_bit2 = 1'b0;                           // R2
              nxt.op_mode_bit1 = 1'b0;
              nxt.op_mode_bit0 = 1'b0;
              nxt.phase        = PH_CONV;
            end
            PH_SELF_ZS: begin
              // zero-scale on shorted inputs, then back to normal
              // full-scale is kept as it was
              nxt.zs_coef      = meas_data;                      // R10
              nxt.op_mode_bit2 = 1'b0;                           // R2
              nxt.op_mode_bit1 = 1'b0;
              nxt.op_mode_bit0 = 1'b0;
              nxt.phase        = PH_CONV;
            end
            PH_BG_ZS: begin
              // offset coefficient refreshed, full-scale left alone
              // after the fifth slot a word follows
              nxt.zs_coef = meas_data;                           // R8
              events[adc_cal_seq_pkg::EV_BG_UPD] = 1'b1;
              nxt.bg_cnt  = cur.bg_cnt + 3'h1;
              if (cur.bg_cnt + 3'h1 == adc_cal_seq_pkg::BG_CAL_SLOTS) begin
                nxt.phase = PH_CONV;                             // R7
              end
            end
          endcase
        end
      end
    endcase

    // unmapped addresses answer zero,
    // the clear register reads as zero
    // register reads: data answered in the next cycle only
    if (rd_en) begin
      unique case (addr)
        adc_cal_seq_pkg::ADDR_MODE: begin
          // fields packed back as written
          nxt.rd_data = 32'({cur.gain,
                             cur.chan_sel_bit2, cur.chan_sel_bit1, cur.chan_sel_bit0,
                             op_mode});
        end
        adc_cal_seq_pkg::ADDR_STATUS: begin
          // live bits, not sticky
          nxt.rd_data[adc_cal_seq_pkg::STAT_READY_N] = cur.ready_n;
          nxt.rd_data[adc_cal_seq_pkg::STAT_CAL]     = cur.cal_pending;
          nxt.rd_data[adc_cal_seq_pkg::STAT_BG]      = (op_mode == adc_cal_seq_pkg::MODE_BG_CAL);
        end
        adc_cal_seq_pkg::ADDR_DATA:       nxt.rd_data = 32'(cur.data_word);
        adc_cal_seq_pkg::ADDR_ZS_COEF:    nxt.rd_data = 32'(cur.zs_coef);
        adc_cal_seq_pkg::ADDR_FS_COEF:    nxt.rd_data = 32'(cur.fs_coef);
        adc_cal_seq_pkg::ADDR_IRQ_STATUS: nxt.rd_data = 32'(cur.irq_stat);
        adc_cal_seq_pkg::ADDR_IRQ_ENABLE: nxt.rd_data = 32'(cur.irq_en);
        default:                          nxt.rd_data = '0; // unmapped or write only
      endcase
    end

    // a word landing now keeps ready low,
    // so no word is lost to the read
    // reading the word consumes it unless a new one lands now
    if (hit_data_rd && !events[adc_cal_seq_pkg::EV_WORD]) begin
      nxt.ready_n = 1'b1;
    end

    // a mode write restarts the sequence
    // and cancels a running measurement;
    // single-step calibration codes also raise ready
    // register writes
    if (wr_en) begin
      unique case (addr)
        adc_cal_seq_pkg::ADDR_MODE: begin
          // new mode restarts the sequence, any running measurement dropped
          nxt.op_mode_bit2  = new_mode[2];
          nxt.op_mode_bit1  = new_mode[1];
          nxt.op_mode_bit0  = new_mode[0];
          nxt.chan_sel_bit2 = wr_data[adc_cal_seq_pkg::CHAN_LSB + 2];
          nxt.chan_sel_bit1 = wr_data[adc_cal_seq_pkg::CHAN_LSB + 1];
          nxt.chan_sel_bit0 = wr_data[adc_cal_seq_pkg::CHAN_LSB];
          nxt.gain          = wr_data[adc_cal_seq_pkg::GAIN_LSB +: adc_cal_seq_pkg::FIELD_W];
          nxt.meas_start    = 1'b0;
          nxt.meas_abort    = (cur.state == ST_WAIT);
          nxt.state         = ST_LAUNCH;
          nxt.bg_cnt        = '0;
          nxt.cal_pending   = 1'b0;
          nxt.phase         = PH_CONV;
          if (new_mode == adc_cal_seq_pkg::MODE_SYS_OFFS) begin
            nxt.phase       = PH_SYS_ZS;                         // R1
            nxt.cal_pending = 1'b1;
            nxt.ready_n     = 1'b1;                              // R3
          end else if (new_mode == adc_cal_seq_pkg::MODE_SELF_ZS) begin
            nxt.phase       = PH_SELF_ZS;                        // R10
            nxt.cal_pending = 1'b1;
            nxt.ready_n     = 1'b1;                              // R11
          end else if (new_mode == adc_cal_seq_pkg::MODE_BG_CAL) begin
            nxt.phase       = PH_CONV;                           // R6
          end
        end
        adc_cal_seq_pkg::ADDR_IRQ_ENABLE: begin
          // enables act from the next cycle
          nxt.irq_en = wr_data[adc_cal_seq_pkg::EV_W-1:0];
        end
        default: begin
          // clear register handled below, others ignore writes
        end
      endcase
    end

    // clear first, then or in events,
    // so the set side always wins
    // sticky events: a new event wins over a clear in the same cycle
    if (wr_en && (addr == adc_cal_seq_pkg::ADDR_IRQ_CLEAR)) begin
      nxt.irq_stat = cur.irq_stat & ~wr_data[adc_cal_seq_pkg::EV_W-1:0];
    end
    nxt.irq_stat = nxt.irq_stat | events;

    // level follows the next sticky bits
    // interrupt level from the enabled sticky bits
    nxt.irq = |(nxt.irq_stat & nxt.irq_en);
  end

  // all fields start from zero, then the
  // few that need other reset values;
  // ready idles high, meaning no word,
  // and the source idles on the input
  // state register with synchronous reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur               <= '0;
      cur.state         <= ST_LAUNCH;
      cur.phase         <= PH_CONV;
      cur.gain          <= adc_cal_seq_pkg::RST_GAIN;
      cur.chan_sel_bit2 <= adc_cal_seq_pkg::RST_CHAN[2];
      cur.chan_sel_bit1 <= adc_cal_seq_pkg::RST_CHAN[1];
      cur.chan_sel_bit0 <= adc_cal_seq_pkg::RST_CHAN[0];
      cur.ready_n       <= 1'b1;
      cur.meas_src      <= adc_cal_seq_pkg::SRC_AIN;
    end else begin
      cur <= nxt;
    end
  end

  // no logic between flops and pins;
  // channel rebuilt from its three bits
  // outputs straight from the state register
  assign rd_data           = cur.rd_data;
  assign meas_start        = cur.meas_start;
  assign meas_abort        = cur.meas_abort;
  assign meas_src          = cur.meas_src;
  assign meas_chan         = {cur.chan_sel_bit2, cur.chan_sel_bit1, cur.chan_sel_bit0};
  assign meas_gain         = cur.gain;
  assign conv_word_ready_n = cur.ready_n;
  assign irq               = cur.irq;

endmodule

/* File: test/adc_cal_sequencer_asserts.sv */
`timescale 1ns/1ps
// port-level checks of the calibration sequencer
module adc_cal_seq_chk #(
  parameter int DATA_W = 24
) (
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic [7:0]        addr,
  input wire logic [31:0]       wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [31:0]       rd_data,
  input wire logic              meas_done,
  input wire logic [DATA_W-1:0] meas_data,
  input wire logic              meas_start,
  input wire logic              meas_abort,
  input wire logic [1:0]        meas_src,
  input wire logic [2:0]        meas_chan,
  input wire logic [2:0]        meas_gain,
  input wire logic              conv_word_ready_n,
  input wire logic              irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic       mode_wr;  // mode register write in this cycle
  logic [2:0] new_mode; // mode field being written
  assign mode_wr  = wr_en && addr == adc_cal_seq_pkg::ADDR_MODE;
  assign new_mode = wr_data[2:0];
  a_rd_idle: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data not idle");
  a_start_pulse: assert property (meas_start |=> !meas_start)
    else $error("start longer than one cycle");
  a_abort_pulse: assert property (meas_abort |=> !meas_abort)
    else $error("abort longer than one cycle");
  a_cal_ready: assert property (mode_wr && new_mode inside {3'h4, 3'h6} |=> conv_word_ready_n)
    else $error("ready not raised at calibration start");
  a_sys_source: assert property (mode_wr && new_mode == 3'h4 |-> ##2 meas_start && meas_src == 2'h0)
    else $error("system offset not on analog input");
  a_self_source: assert property (mode_wr && new_mode == 3'h6 |-> ##2 meas_start && meas_src == 2'h1)
    else $error("self calibration not on shorted inputs");
  a_chan_gain: assert property (mode_wr |-> ##2 meas_start && meas_chan == $past(wr_data[5:3], 2)
    && meas_gain == $past(wr_data[8:6], 2))
    else $error("channel or gain not taken from mode write");
  a_read_ready: assert property (rd_en && addr == 8'h08 && !meas_done |=> conv_word_ready_n)
    else $error("data read left ready low");
endmodule

bind adc_cal_sequencer adc_cal_seq_chk #(.DATA_W(DATA_W)) chk_u (
  .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .meas_done(meas_done), .meas_data(meas_data), .meas_start(meas_start),
  .meas_abort(meas_abort), .meas_src(meas_src), .meas_chan(meas_chan), .meas_gain(meas_gain),
  .conv_word_ready_n(conv_word_ready_n), .irq(irq)
);

/* File: test/fe_model.sv */
`timescale 1ns/1ps
// front end stand-in: answers each start once, lat cycles later
module fe_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        meas_start,
  input  wire logic        meas_abort,
  input  wire logic [1:0]  meas_src,
  input  wire logic [2:0]  meas_chan,
  input  wire logic [2:0]  meas_gain,
  input  wire logic [3:0]  lat,       // answer delay in cycles
  input  wire logic [23:0] ain_val,   // voltage on the analog input
  input  wire logic [23:0] short_val, // offset seen on shorted inputs
  input  wire logic [23:0] ref_val,   // internal reference at unity gain
  output logic             meas_done,
  output logic [23:0]      meas_data
);
  logic [3:0]  cnt; // cycles left, 0 when idle
  logic [23:0] res; // result of the running measurement
  // an abort drops the answer; data lines toggle outside the done cycle
  always_ff @(posedge clk_sys) begin
    meas_done <= 1'b0;
    meas_data <= ~meas_data;
    if (rst || meas_abort) begin
      cnt       <= 4'h0;
      meas_data <= 24'h0;
    end else if (meas_start) begin
      cnt <= lat;
      if (meas_src == adc_cal_seq_pkg::SRC_AIN) res <= ain_val + 24'(meas_chan);
      else if (meas_src == adc_cal_seq_pkg::SRC_SHORT) res <= short_val;
      else res <= ref_val >> meas_gain;
    end else if (cnt == 4'h1) begin
      cnt       <= 4'h0;
      meas_done <= 1'b1;
      meas_data <= res;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule

/* File: test/tb_adc_cal_sequencer.sv */
`timescale 1ns/1ps
// bench: host register traffic from tasks, front end from a model
module tb_adc_cal_sequencer;
  logic        clk_sys;
  logic        rst     = 1'b1;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic        rd_seen = 1'b0;     // a read was taken last edge
  logic [31:0] rd_data;
  logic        meas_done, meas_start, meas_abort, conv_word_ready_n, irq;
  logic [23:0] meas_data, ain_val, short_val, ref_val, a, d, f, s;
  logic [1:0]  meas_src;
  logic [2:0]  meas_chan, meas_gain, ch, g;
  logic [3:0]  lat;
  logic [31:0] exp_q[$], msk_q[$]; // expected read notes
  int          n_errors = 0;
  int          num_checks = 0;
  int          n_starts = 0;       // measurement starts seen
  int          n_aborts = 0;       // measurement cancels seen
  int          cycles = 0;
  adc_cal_sequencer #(.DATA_W(24)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .meas_done(meas_done), .meas_data(meas_data),
    .meas_start(meas_start), .meas_abort(meas_abort), .meas_src(meas_src), .meas_chan(meas_chan),
    .meas_gain(meas_gain), .conv_word_ready_n(conv_word_ready_n), .irq(irq));
  fe_model fe_u (
    .clk_sys(clk_sys), .rst(rst), .meas_start(meas_start), .meas_abort(meas_abort),
    .meas_src(meas_src), .meas_chan(meas_chan), .meas_gain(meas_gain), .lat(lat),
    .ain_val(ain_val), .short_val(short_val), .ref_val(ref_val), .meas_done(meas_done),
    .meas_data(meas_data));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk_sys);
    addr    <= ad;
    wr_data <= v;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
  endtask
  // a read notes its expectation; the monitor compares it a cycle later
  task automatic rd(input logic [7:0] ad, input logic [23:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge clk_sys);
    addr  <= ad;
    rd_en <= 1'b1;
    exp_q.push_back({8'h00, e});
    msk_q.push_back(m);
    @(posedge clk_sys);
    rd_en <= 1'b0;
  endtask
  // bounded wait for a fresh word or for a start on a given source
  task automatic wait_for(input logic word, input logic [1:0] sv);
    int i;
    for (i = 0; i < 500; i++) begin
      @(negedge clk_sys);
      if (word ? conv_word_ready_n === 1'b0 : meas_start === 1'b1 && meas_src === sv) break;
    end
    chk(i < 500, "wait ran out");
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(negedge clk_sys);
    chk(irq === v, "irq level wrong");
  endtask
  function automatic logic [31:0] mw(input logic [2:0] m);
    return {23'h0, g, ch, m};
  endfunction
  // monitor: read results, start count and the hang limit
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
    if (rd_seen === 1'b1) begin
      chk((rd_data & msk_q[0]) === (exp_q[0] & msk_q[0]), "read data mismatch");
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (meas_start === 1'b1) n_starts++;
    if (meas_abort === 1'b1) n_aborts++;
    rd_seen <= rd_en;
  end
  initial begin
    void'($urandom(68));
    a = 24'($urandom);
    d = 24'($urandom);
    f = 24'($urandom);
    s = 24'($urandom);
    ch = 3'($urandom);
    g = 3'($urandom);
    lat = 4'(4 + $urandom_range(7));
    ain_val = a;
    short_val = s;
    ref_val = f;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk(conv_word_ready_n === 1'b1 && irq === 1'b0, "reset outputs");
    rd(8'h04, 24'h1);
    rd(8'h00, 24'h0);
    rd(8'h18, 24'h0);
    rd(8'h20, 24'h0);
    wr(8'h1C, 32'h2);
    rd(8'h1C, 24'h2);
    wr(8'h18, 32'h7);
    // system offset: zero scale from the input, full scale from the reference
    wait_for(1'b0, 2'h0);
    wr(8'h00, mw(3'h4));
    wait_for(1'b0, 2'h2);
    @(posedge clk_sys);
    ain_val <= a + d;
    wait_for(1'b1, 2'h0);
    rd(8'h0C, a + 24'(ch));
    rd(8'h10, f >> g);
    rd(8'h00, 24'({g, ch, 3'h0}));
    rd(8'h08, d);
    rd(8'h14, 24'h3, 32'h7);
    irq_is(1'b1);
    wr(8'h1C, 32'h0);
    irq_is(1'b0);
    wr(8'h1C, 32'h2);
    irq_is(1'b1);
    wr(8'h18, 32'h2);
    irq_is(1'b0);
    // zero-scale self calibration ahead of background mode
    wait_for(1'b0, 2'h0);
    wr(8'h00, mw(3'h6));
    rd(8'h04, 24'h3, 32'h7);
    wait_for(1'b1, 2'h0);
    rd(8'h0C, s);
    rd(8'h00, 24'({g, ch, 3'h0}));
    rd(8'h08, a + d + 24'(ch) - s);
    rd(8'h14, 24'h2, 32'h2);
    // background: six starts per word, offset refreshed, full scale kept
    s = 24'($urandom);
    short_val <= s;
    wait_for(1'b0, 2'h0);
    wr(8'h00, mw(3'h5));
    rd(8'h08, 24'h0, 32'h0);
    wait_for(1'b1, 2'h0);
    n_starts = 0;
    rd(8'h08, 24'h0, 32'h0);
    wait_for(1'b1, 2'h0);
    chk(n_starts == 6, "background word rate");
    rd(8'h08, a + d + 24'(ch) - s);
    rd(8'h0C, s);
    rd(8'h10, f >> g);
    rd(8'h00, 24'({g, ch, 3'h5}));
    rd(8'h04, 24'h4, 32'h6);
    chk(n_aborts == 3, "abort count wrong"); // one per mode write while waiting
    repeat (3) @(posedge clk_sys);
    test_done();
  end
endmodule
